// ### umr_regs.vh
`ifndef UMR_REGS_VH
`define UMR_REGS_VH

// APB byte offsets; each register takes one aligned 32-bit word.
`define UMR_OFF_MODE_A 8'h00
`define UMR_OFF_STATUS_A 8'h04
`define UMR_OFF_COMMAND_A 8'h08
`define UMR_OFF_AUX_IPCHG 8'h10
`define UMR_OFF_INT 8'h14
`define UMR_OFF_CNT_UPPER 8'h18
`define UMR_OFF_CNT_LOWER 8'h1c
`define UMR_OFF_OUT_BITS 8'h20
`define UMR_OFF_VECTOR 8'h30
`define UMR_OFF_OUT_CONFIG 8'h34
`define UMR_OFF_OUT_SET 8'h38
`define UMR_OFF_OUT_CLEAR 8'h3c

// First mode register fields.
`define UMR_MR1_FLOW_BIT 7
`define UMR_MR1_RXINT_BIT 6
`define UMR_MR1_ERRMODE_BIT 5
`define UMR_MR1_PMODE_HI 4
`define UMR_MR1_PMODE_LO 3
`define UMR_MR1_PTYPE_BIT 2
`define UMR_MR1_BPC_HI 1
`define UMR_MR1_BPC_LO 0

// Parity mode encodings.
`define UMR_PAR_WITH 2'b00
`define UMR_PAR_FORCE 2'b01
`define UMR_PAR_NONE 2'b10
`define UMR_PAR_MULTI 2'b11

// Command register, upper nibble.
`define UMR_CMD_SET_PTR 4'h1
`define UMR_CMD_RX_RESET 4'h2
`define UMR_CMD_ERR_RESET 4'h4

// Auxiliary control fields.
`define UMR_ACR_BRG_BIT 7
`define UMR_ACR_CT_HI 6
`define UMR_ACR_CT_LO 4

// Interrupt status and mask bit positions.
`define UMR_ISR_IPCHG 7
`define UMR_ISR_BRK_B 6
`define UMR_ISR_RX_B 5
`define UMR_ISR_TX_B 4
`define UMR_ISR_CNT 3
`define UMR_ISR_BRK_A 2
`define UMR_ISR_RX_A 1
`define UMR_ISR_TX_A 0

// Output port configuration bit giving pin four to the receiver interrupt.
`define UMR_OUTPUT_PORT_CONFIG_PIN4_BIT 4

// Reset values.
`define UMR_RST_BYTE 8'h00
`define UMR_RST_WORD 32'h0000_0000

`endif

// ### umr_parity.v
`timescale 1ns/1ps
`default_nettype none
`include "umr_regs.vh"

module umr_parity #(
    parameter DATA_W = 8
) (
    // Character and mode
    input wire [DATA_W-1:0] data,
    input wire [1:0] bits_per_char,
    input wire [1:0] parity_mode,
    input wire parity_type,
    // Received parity position
    input wire rx_parity_bit,
    // Results
    output reg gen_enable,
    output reg gen_bit,
    output reg check_fault
);

    integer i;
    reg ones;

    always @* begin
        ones = 1'b0;
        for (i = 0; i < DATA_W; i = i + 1) begin
            if (i < 5 + bits_per_char) begin
                ones = ones ^ data[i];
            end
        end
        gen_enable = 1'b1;
        gen_bit = 1'b0;
        check_fault = 1'b0;
        case (parity_mode)
            // R12: odd or even
            `UMR_PAR_WITH: begin
                gen_bit = ones ^ parity_type;
                check_fault = rx_parity_bit ^ gen_bit;
            end
            // R13: forced polarity
            `UMR_PAR_FORCE: begin
                gen_bit = parity_type;
                check_fault = rx_parity_bit ^ gen_bit;
            end
            // R15: address flag polarity
            `UMR_PAR_MULTI: begin
                gen_bit = parity_type;
            end
            // R14: type bit ignored
            default: begin
                gen_enable = 1'b0;
            end
        endcase
    end

endmodule // umr_parity

`default_nettype wire

// ### umr_top.v
//
// Function
// R01: Mode access uses a pointer; reset or set-pointer command selects first mode.
// R02: Any first mode read or write moves the pointer to second mode.
// R03: Flow request output follows output port bit zero.
// R04: With flow enable, valid start bit while FIFO full negates the output.
// R05: Auto negation leaves bit zero alone; reassert once a FIFO slot frees.
// R06: Mode bit six picks char-available or FIFO-full as receiver interrupt.
// R07: That selection also drives pin four when configured as interrupt.
// R08: Character error mode shows errors of the top FIFO character only.
// R09: Block error mode ORs errors of all top characters since reset-error.
// R10: With or forced parity, transmitter adds parity and receiver checks it.
// R11: Parity mode binary 11 selects multidrop mode.
// R12: With parity, type bit selects odd or even for both directions.
// R13: Forced parity, type bit is the fixed parity value.
// R14: No parity, type bit has no effect.
// R15: Multidrop, type bit sets the address/data flag polarity.
// R16: Auxiliary bit seven selects baud rate set one or two.
// R17: Software clears block errors by reset-error or receiver reset command.
// R18: Interrupt output asserted when any status bit and its mask are set.
// R19: Input change flags set on level change, cleared by reading them.
// R20: Counter value is sixteen bits, upper and lower byte registers.
//
`timescale 1ns/1ps
`default_nettype none
`include "umr_regs.vh"

module umr_top #(
    parameter ADDR_W = 8,
    parameter DATA_W = 32,
    parameter IN_W = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [DATA_W-1:0] pwdata,
    output reg [DATA_W-1:0] prdata,
    output reg pready,
    output reg pslverr,
    // Receiver state from the serial datapath
    input wire rx_char_available,
    input wire receive_fifo_full,
    input wire rx_start_valid,
    input wire rx_top_load,
    input wire rx_top_framing_fault,
    input wire rx_top_parity_fault,
    input wire rx_top_break,
    input wire rx_overrun,
    input wire [7:0] rx_data,
    input wire rx_parity_bit,
    // Transmitter and other interrupt sources
    input wire tx_empty,
    input wire tx_ready_a,
    input wire tx_ready_b,
    input wire rx_int_b,
    input wire break_delta_a,
    input wire break_delta_b,
    input wire counter_ready,
    input wire [7:0] tx_data,
    // Change-detecting input pins
    input wire [IN_W-1:0] input_port,
    // Pins
    output reg rx_flow_request_out_n,
    output reg output_pin_four_n,
    output reg irq_n,
    // Configuration towards the datapath
    output reg baud_set_select,
    output reg [2:0] counter_mode,
    output reg [15:0] counter_preset,
    output reg [7:0] interrupt_vector,
    output reg [7:0] mode_first,
    output reg [7:0] chan_a_mode_second,
    output reg [7:0] output_port_bits,
    output reg multidrop_mode,
    output reg rx_reset_pulse,
    // Parity results
    output reg tx_parity_enable,
    output reg tx_parity_bit,
    output reg rx_parity_fault
);

    localparam PTR_FIRST = 1'b0;
    localparam PTR_SECOND = 1'b1;

    reg mr_ptr;
    reg [7:0] aux_control;
    reg [7:0] interrupt_mask;
    reg [7:0] output_port_config;
    reg [7:0] ct_upper;
    reg [7:0] ct_lower;
    reg [IN_W-1:0] in_prev;
    reg in_primed;
    reg [IN_W-1:0] in_delta;
    reg [2:0] err_acc;
    reg flow_hold;

    wire setup;
    wire wr_en;
    wire rd_en;
    wire [3:0] cmd_code;
    wire cmd_wr;
    wire err_clear;
    wire rx_int_sel;
    wire [2:0] err_view;
    wire [7:0] status_a;
    wire [7:0] input_change_status_view;
    wire [7:0] isr_view;
    wire [IN_W-1:0] in_change;
    wire par_en;
    wire par_bit;
    wire par_fault;
    reg [7:0] rd_byte;
    reg rd_hit;

    // The reply takes one wait state so that prdata comes from a flop.
    assign setup = psel & penable & ~pready;
    assign wr_en = setup & pwrite;
    assign rd_en = setup & ~pwrite;
    assign cmd_code = pwdata[7:4];
    assign cmd_wr = wr_en & (paddr == `UMR_OFF_COMMAND_A);
    // R17: error reset commands
    assign err_clear = cmd_wr & ((cmd_code == `UMR_CMD_ERR_RESET) |
        (cmd_code == `UMR_CMD_RX_RESET));

    // R06: receiver interrupt source
    assign rx_int_sel = mode_first[`UMR_MR1_RXINT_BIT] ? receive_fifo_full : rx_char_available;

    // R08: per-character errors
    // R09: accumulated errors
    assign err_view = mode_first[`UMR_MR1_ERRMODE_BIT] ? err_acc :
        {rx_top_break, rx_top_framing_fault, rx_top_parity_fault};

    assign status_a = {err_view, rx_overrun, tx_empty, tx_ready_a,
        receive_fifo_full, rx_char_available};

    assign input_change_status_view = {in_delta, in_prev};
    assign in_change = in_primed ? (input_port ^ in_prev) : {IN_W{1'b0}};

    assign isr_view = {
        |(in_delta & aux_control[IN_W-1:0]),
        break_delta_b,
        rx_int_b,
        tx_ready_b,
        counter_ready,
        break_delta_a,
        rx_int_sel,
        tx_ready_a
    };

    // R10: parity for transmit data
    umr_parity #(
        .DATA_W(8)
    ) u_par_tx (
        .data(tx_data),
        .bits_per_char(mode_first[`UMR_MR1_BPC_HI:`UMR_MR1_BPC_LO]),
        .parity_mode(mode_first[`UMR_MR1_PMODE_HI:`UMR_MR1_PMODE_LO]),
        .parity_type(mode_first[`UMR_MR1_PTYPE_BIT]),
        .rx_parity_bit(1'b0),
        .gen_enable(par_en),
        .gen_bit(par_bit),
        .check_fault()
    );

    // R10: parity check of received data
    umr_parity #(
        .DATA_W(8)
    ) u_par_rx (
        .data(rx_data),
        .bits_per_char(mode_first[`UMR_MR1_BPC_HI:`UMR_MR1_BPC_LO]),
        .parity_mode(mode_first[`UMR_MR1_PMODE_HI:`UMR_MR1_PMODE_LO]),
        .parity_type(mode_first[`UMR_MR1_PTYPE_BIT]),
        .rx_parity_bit(rx_parity_bit),
        .gen_enable(),
        .gen_bit(),
        .check_fault(par_fault)
    );

    // Read data selection; aux control and interrupt mask share addresses with read registers, other write-only ones read as zero.
    always @* begin
        rd_byte = `UMR_RST_BYTE;
        rd_hit = 1'b1;
        case (paddr)
            `UMR_OFF_MODE_A: rd_byte = (mr_ptr == PTR_FIRST) ? mode_first : chan_a_mode_second;
            `UMR_OFF_STATUS_A: rd_byte = status_a;
            `UMR_OFF_AUX_IPCHG: rd_byte = input_change_status_view;
            `UMR_OFF_INT: rd_byte = isr_view;
            `UMR_OFF_CNT_UPPER: rd_byte = ct_upper;
            `UMR_OFF_CNT_LOWER: rd_byte = ct_lower;
            `UMR_OFF_OUT_BITS: rd_byte = output_port_bits;
            `UMR_OFF_VECTOR: rd_byte = interrupt_vector;
            `UMR_OFF_COMMAND_A, `UMR_OFF_OUT_CONFIG: rd_byte = `UMR_RST_BYTE;
            `UMR_OFF_OUT_SET, `UMR_OFF_OUT_CLEAR: rd_byte = `UMR_RST_BYTE;
            default: rd_hit = 1'b0;
        endcase
    end

    // APB reply.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `UMR_RST_WORD;
        end else begin
            pready <= setup;
            pslverr <= setup & ~rd_hit;
            if (rd_en) begin
                prdata <= {24'h00_0000, rd_byte};
            end else begin
                prdata <= `UMR_RST_WORD;
            end
        end
    end

    // Mode pointer and mode registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr_ptr <= PTR_FIRST;
            mode_first <= `UMR_RST_BYTE;
            chan_a_mode_second <= `UMR_RST_BYTE;
        end else begin
            if (setup & (paddr == `UMR_OFF_MODE_A)) begin
                if (mr_ptr == PTR_FIRST) begin
                    if (pwrite) begin
                        mode_first <= pwdata[7:0];
                    end
                    // R02: advance after access
                    mr_ptr <= PTR_SECOND;
                end else if (pwrite) begin
                    chan_a_mode_second <= pwdata[7:0];
                end
            end
            // R01: set-pointer command
            if (cmd_wr & (cmd_code == `UMR_CMD_SET_PTR)) begin
                mr_ptr <= PTR_FIRST;
            end
        end
    end

    // Control registers and output port bits.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_control <= `UMR_RST_BYTE;
            interrupt_mask <= `UMR_RST_BYTE;
            output_port_config <= `UMR_RST_BYTE;
            ct_upper <= `UMR_RST_BYTE;
            ct_lower <= `UMR_RST_BYTE;
            interrupt_vector <= `UMR_RST_BYTE;
            output_port_bits <= `UMR_RST_BYTE;
        end else if (wr_en) begin
            case (paddr)
                `UMR_OFF_AUX_IPCHG: aux_control <= pwdata[7:0];
                `UMR_OFF_INT: interrupt_mask <= pwdata[7:0];
                // R20: counter bytes
                `UMR_OFF_CNT_UPPER: ct_upper <= pwdata[7:0];
                `UMR_OFF_CNT_LOWER: ct_lower <= pwdata[7:0];
                `UMR_OFF_VECTOR: interrupt_vector <= pwdata[7:0];
                `UMR_OFF_OUT_CONFIG: output_port_config <= pwdata[7:0];
                `UMR_OFF_OUT_SET: output_port_bits <= output_port_bits | pwdata[7:0];
                `UMR_OFF_OUT_CLEAR: output_port_bits <= output_port_bits & ~pwdata[7:0];
                default: output_port_bits <= output_port_bits;
            endcase
        end
    end

    // Input change detection; the first sample after reset only primes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_prev <= {IN_W{1'b0}};
            in_primed <= 1'b0;
            in_delta <= {IN_W{1'b0}};
        end else begin
            in_prev <= input_port;
            in_primed <= 1'b1;
            // R19: set wins over read clear
            if (rd_en & (paddr == `UMR_OFF_AUX_IPCHG)) begin
                in_delta <= in_change;
            end else begin
                in_delta <= in_delta | in_change;
            end
        end
    end

    // Block error accumulation; a new top character wins over a clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_acc <= 3'b000;
        end else begin
            // R09: accumulate or clear
            if (rx_top_load) begin
                err_acc <= (err_clear ? 3'b000 : err_acc) |
                    {rx_top_break, rx_top_framing_fault, rx_top_parity_fault};
            end else if (err_clear) begin
                err_acc <= 3'b000;
            end
        end
    end

    // Receiver flow hold; releasing as soon as the FIFO has room.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_hold <= 1'b0;
        end else begin
            // R04: negate on start bit when full
            if (mode_first[`UMR_MR1_FLOW_BIT] & rx_start_valid & receive_fifo_full) begin
                flow_hold <= 1'b1;
            // R05: reassert when not full
            end else if (~receive_fifo_full) begin
                flow_hold <= 1'b0;
            end
        end
    end

    // Registered outputs. Pin levels are the inverse of the asserted state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_flow_request_out_n <= 1'b1;
            output_pin_four_n <= 1'b1;
            irq_n <= 1'b1;
            baud_set_select <= 1'b0;
            counter_mode <= 3'b000;
            counter_preset <= 16'h0000;
            multidrop_mode <= 1'b0;
            rx_reset_pulse <= 1'b0;
            tx_parity_enable <= 1'b0;
            tx_parity_bit <= 1'b0;
            rx_parity_fault <= 1'b0;
        end else begin
            // R03: follow bit zero
            // R05: bit zero untouched by hold
            rx_flow_request_out_n <= ~(output_port_bits[0] & ~flow_hold);
            // R07: pin four as interrupt
            if (output_port_config[`UMR_OUTPUT_PORT_CONFIG_PIN4_BIT]) begin
                output_pin_four_n <= ~rx_int_sel;
            end else begin
                output_pin_four_n <= ~output_port_bits[4];
            end
            // R18: masked interrupt
            irq_n <= ~|(isr_view & interrupt_mask);
            // R16: baud set select
            baud_set_select <= aux_control[`UMR_ACR_BRG_BIT];
            counter_mode <= aux_control[`UMR_ACR_CT_HI:`UMR_ACR_CT_LO];
            // R20: sixteen bit value
            counter_preset <= {ct_upper, ct_lower};
            // R11: multidrop select
            multidrop_mode <= (mode_first[`UMR_MR1_PMODE_HI:`UMR_MR1_PMODE_LO] ==
                `UMR_PAR_MULTI);
            rx_reset_pulse <= cmd_wr & (cmd_code == `UMR_CMD_RX_RESET);
            // R10: add and check parity
            tx_parity_enable <= par_en;
            tx_parity_bit <= par_bit;
            rx_parity_fault <= par_fault;
        end
    end

endmodule // umr_top

`default_nettype wire

// ### umr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module umr_chk #(
    parameter ADDR_W = 8,
    parameter DATA_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Datapath
    input wire logic receive_fifo_full,
    input wire logic rx_start_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_parity_bit,
    input wire logic [7:0] tx_data,
    // Outputs
    input wire logic rx_flow_request_out_n,
    input wire logic baud_set_select,
    input wire logic [7:0] mode_first,
    input wire logic [7:0] output_port_bits,
    input wire logic multidrop_mode,
    input wire logic rx_reset_pulse,
    input wire logic tx_parity_enable,
    input wire logic tx_parity_bit,
    input wire logic rx_parity_fault
);
    logic up, tp, rp;
    logic [7:0] msk;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Outputs at the first edge after reset still come from reset, so skip it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) up <= 1'b0;
        else up <= 1'b1;
    end
    assign msk = 8'hff >> (2'd3 - mode_first[1:0]);
    assign tp = ^(tx_data & msk) ^ mode_first[2];
    assign rp = rx_parity_bit ^ ^(rx_data & msk) ^ mode_first[2];
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    rx_reset_a: assert property (psel && penable && pwrite && !pready && paddr == 8'h08 &&
        pwdata[7:4] == 4'h2 |=> rx_reset_pulse ##1 !rx_reset_pulse)
        else $error("no receiver reset pulse");
    flow_follow_a: assert property (output_port_bits[0] && !receive_fifo_full ##1
        output_port_bits[0] && !receive_fifo_full |=> !rx_flow_request_out_n)
        else $error("flow request not asserted");
    flow_off_a: assert property (!output_port_bits[0] |=> rx_flow_request_out_n)
        else $error("flow request without port bit");
    flow_stop_a: assert property (mode_first[7] && rx_start_valid && receive_fifo_full
        ##1 receive_fifo_full |=> rx_flow_request_out_n) else $error("flow not negated");
    baud_write_a: assert property (psel && penable && pwrite && !pready && paddr == 8'h10
        |-> ##2 baud_set_select == $past(pwdata[7], 2)) else $error("baud set not written");
    multidrop_a: assert property ($stable(mode_first) |->
        multidrop_mode == (mode_first[4:3] == 2'b11)) else $error("multidrop wrong");
    par_on_a: assert property (up && !$past(mode_first[4]) |-> tx_parity_enable)
        else $error("parity not added");
    par_off_a: assert property (up && $past(mode_first[4:3]) == 2'b10 |-> !tx_parity_enable)
        else $error("parity added in no parity mode");
    par_fixed_a: assert property (up && $past(mode_first[3]) |->
        tx_parity_bit == $past(mode_first[2])) else $error("fixed parity bit wrong");
    par_gen_a: assert property (up && $past(mode_first[4:3]) == 2'b00 |->
        tx_parity_bit == $past(tp)) else $error("parity wrong");
    par_check_a: assert property (up && $past(mode_first[4:3]) == 2'b00 |->
        rx_parity_fault == $past(rp))
        else $error("parity check wrong");
    cover property (mode_first[7] && rx_start_valid && receive_fifo_full);
    cover property (pslverr);
    cover property (multidrop_mode);
endmodule // umr_chk
bind umr_top umr_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) umr_chk_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .receive_fifo_full,
    .rx_start_valid, .rx_data, .rx_parity_bit, .tx_data, .rx_flow_request_out_n,
    .baud_set_select, .mode_first, .output_port_bits, .multidrop_mode, .tx_parity_enable,
    .tx_parity_bit, .rx_parity_fault, .rx_reset_pulse);
`default_nettype wire

// ### umr_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module umr_rx_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench commands
    input wire logic push,
    input wire logic pop,
    input wire logic [2:0] err_in,
    // Receiver state
    output logic rx_char_available,
    output logic receive_fifo_full,
    output logic rx_start_valid,
    output logic rx_top_load,
    output logic rx_top_break,
    output logic rx_top_framing_fault,
    output logic rx_top_parity_fault
);
    logic [2:0] q[$];
    logic [2:0] pend_err;
    logic pend;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.delete();
            {pend, pend_err, rx_start_valid, rx_top_load} <= 6'h00;
            {rx_char_available, receive_fifo_full} <= 2'b00;
            {rx_top_break, rx_top_framing_fault, rx_top_parity_fault} <= 3'b000;
        end else begin
            // The start bit shows a frame before its character lands.
            rx_start_valid <= push;
            pend <= push;
            pend_err <= err_in;
            rx_top_load <= 1'b0;
            // A character that meets a full FIFO is lost.
            if (pend && q.size() < 4) begin
                q.push_back(pend_err);
                if (q.size() == 1) rx_top_load <= 1'b1;
            end
            if (pop && q.size() > 0) begin
                void'(q.pop_front());
                if (q.size() > 0) rx_top_load <= 1'b1;
            end
            rx_char_available <= q.size() > 0;
            receive_fifo_full <= q.size() == 4;
            {rx_top_break, rx_top_framing_fault, rx_top_parity_fault} <=
                (q.size() > 0) ? q[0] : 3'b000;
        end
    end
endmodule // umr_rx_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, push, pop;
    logic [7:0] paddr, rx_data, tx_data, interrupt_vector, mode_first, chan_a_mode_second;
    logic [7:0] output_port_bits, lv;
    logic [31:0] pwdata, prdata, rdv;
    logic [2:0] err_in, counter_mode;
    logic [3:0] input_port;
    logic [15:0] counter_preset;
    logic rx_char_available, receive_fifo_full, rx_start_valid, rx_top_load, rx_overrun;
    logic rx_top_framing_fault, rx_top_parity_fault, rx_top_break, rx_parity_bit, rerr;
    logic tx_empty, tx_ready_a, tx_ready_b, rx_int_b, break_delta_a, break_delta_b;
    logic counter_ready, rx_flow_request_out_n, output_pin_four_n, irq_n, baud_set_select;
    logic multidrop_mode, rx_reset_pulse, tx_parity_enable, tx_parity_bit, rx_parity_fault;
    logic [9:0] rows [9] = '{10'h00e, 10'h01f, 10'h003, 10'h02e, 10'h03f, 10'h04c,
        10'h05c, 10'h06e, 10'h07f};
    int miscompares, cmp_count;
    assign {tx_empty, break_delta_b, rx_int_b, tx_ready_b, counter_ready, break_delta_a,
        rx_overrun, tx_ready_a} = lv;
    umr_top umr_top_inst (.*);
    umr_rx_model umr_rx_model_inst (.*);
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task chk(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task put(input logic [2:0] e);
        err_in <= e;
        push <= 1'b1;
        @(posedge pclk);
        push <= 1'b0;
        wt(4);
    endtask
    task take;
        pop <= 1'b1;
        @(posedge pclk);
        pop <= 1'b0;
        wt(4);
    endtask
    task end_sim;
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite, push, pop, paddr, pwdata, err_in, lv} = '0;
        {rx_data, tx_data, rx_parity_bit, input_port} = {8'h35, 8'h35, 1'b1, 4'h0};
        wt(2);
        presetn <= 1'b1;
        wt(1);
        chk({irq_n, rx_flow_request_out_n, output_pin_four_n}, 3'b111);
        apb(1, 8'h00, 8'h83);
        chk(mode_first, 8'h83);
        apb(1, 8'h00, 8'h5a);
        chk({mode_first, chan_a_mode_second}, 16'h835a);
        apb(1, 8'h08, 8'h10);
        apb(0, 8'h00, 8'h00);
        chk(rdv, 32'h83);
        apb(1, 8'h00, 8'h66);
        chk(chan_a_mode_second, 8'h66);
        foreach (rows[i]) begin
            apb(1, 8'h08, 8'h10);
            apb(1, 8'h00, rows[i][9:2]);
            wt(2);
            chk(tx_parity_enable, rows[i][1]);
            if (rows[i][1]) chk(tx_parity_bit, rows[i][0]);
            chk(multidrop_mode, rows[i][6:5] == 2'b11);
            chk(rx_parity_fault, !rows[i][6] && !rows[i][0]);
        end
        apb(1, 8'h08, 8'h10);
        apb(1, 8'h00, 8'h83);
        apb(1, 8'h38, 8'h01);
        wt(2);
        chk(rx_flow_request_out_n, 1'b0);
        repeat (5) put(3'b000);
        chk(rx_flow_request_out_n, 1'b1);
        apb(0, 8'h20, 8'h00);
        chk(rdv[0], 1'b1);
        take;
        chk(rx_flow_request_out_n, 1'b0);
        apb(1, 8'h3c, 8'h01);
        wt(2);
        chk(rx_flow_request_out_n, 1'b1);
        apb(1, 8'h14, 8'h02);
        apb(1, 8'h34, 8'h10);
        wt(2);
        chk({irq_n, output_pin_four_n}, 2'b00);
        apb(1, 8'h08, 8'h10);
        apb(1, 8'h00, 8'hc3);
        wt(2);
        chk({irq_n, output_pin_four_n}, 2'b11);
        put(3'b000);
        chk({irq_n, output_pin_four_n}, 2'b00);
        lv <= 8'h50;
        apb(1, 8'h14, 8'h00);
        wt(2);
        chk(irq_n, 1'b1);
        apb(0, 8'h14, 8'h00);
        chk(rdv, 32'h52);
        apb(1, 8'h14, 8'h40);
        wt(2);
        chk(irq_n, 1'b0);
        lv <= 8'h00;
        repeat (4) take;
        put(3'b101);
        put(3'b000);
        apb(0, 8'h04, 8'h00);
        chk(rdv[7:5], 3'b101);
        take;
        apb(0, 8'h04, 8'h00);
        chk(rdv[7:5], 3'b000);
        apb(1, 8'h08, 8'h10);
        apb(1, 8'h00, 8'he3);
        apb(1, 8'h08, 8'h40);
        put(3'b010);
        take;
        put(3'b001);
        take;
        apb(0, 8'h04, 8'h00);
        chk(rdv[7:5], 3'b011);
        apb(1, 8'h08, 8'h20);
        apb(0, 8'h04, 8'h00);
        chk(rdv[7:5], 3'b000);
        apb(1, 8'h10, 8'h81);
        chk({baud_set_select, counter_mode}, 4'h8);
        input_port <= 4'h5;
        wt(3);
        apb(0, 8'h10, 8'h00);
        chk(rdv, 32'h55);
        apb(0, 8'h10, 8'h00);
        chk(rdv, 32'h05);
        apb(1, 8'h14, 8'h80);
        input_port <= 4'h4;
        wt(3);
        chk(irq_n, 1'b0);
        apb(1, 8'h18, 8'ha5);
        apb(1, 8'h1c, 8'h5a);
        chk(counter_preset, 16'ha55a);
        apb(0, 8'h18, 8'h00);
        chk(rdv, 32'ha5);
        apb(1, 8'h30, 8'h3c);
        apb(0, 8'h30, 8'h00);
        chk({rdv[7:0], interrupt_vector}, 16'h3c3c);
        apb(1, 8'h0c, 8'hff);
        chk(rerr, 1'b1);
        apb(0, 8'h0c, 8'h00);
        chk({rerr, rdv}, 33'h100000000);
        presetn <= 1'b0;
        wt(1);
        presetn <= 1'b1;
        wt(1);
        chk({baud_set_select, counter_preset, irq_n}, 18'h00001);
        apb(1, 8'h00, 8'h11);
        chk(mode_first, 8'h11);
        end_sim;
    end
endmodule // tb
`default_nettype wire
